// ===== pdc_pkg.sv
// Package with register map, field layout and reset values of the pad and dejitter configuration block
package pdc_pkg;
    localparam logic [15:0] PULL_CFG_ADDR = 16'h402F;
    localparam logic [15:0] DRIVE_ADDR = 16'h4030;
    localparam logic [15:0] JACK_ADDR = 16'h4031;
    localparam logic [15:0] DEJITTER_ADDR = 16'h4036;
    localparam logic [15:0] REC_VOL_ADDR = 16'h4040;
    localparam logic [15:0] DEJITTER_STAT_ADDR = 16'h4041;
    localparam logic [7:0] PULL_CFG_RST = 8'hAA;
    localparam logic [7:0] DRIVE_RST = 8'h00;
    localparam logic [7:0] JACK_RST = 8'h08;
    localparam logic [7:0] DEJITTER_RST = 8'h03;
    localparam logic [5:0] REC_VOL_RST = 6'h10;
    localparam int DIN_LSB = 6;
    localparam int LATCH_LSB = 4;
    localparam int CLK_LSB = 2;
    localparam int DOUT_LSB = 0;
    localparam int DRV_BIT = 0;
    localparam int JACK_DRV_BIT = 5;
    localparam int JACK_PULL_LSB = 2;
    localparam int GAIN_STEP_MDB = 750;
    localparam int GAIN_BASE_MDB = -12000;
    typedef enum logic [1:0] {
        PULL_UP = 2'h0,
        PULL_RSVD = 2'h1,
        PULL_NONE = 2'h2,
        PULL_DOWN = 2'h3
    } pdc_pull_type;
    typedef struct packed {
        logic pull_up;
        logic pull_down;
    } pdc_pad_type;
    typedef struct packed {
        logic valid;
        logic [23:0] data;
    } pdc_sample_type;
endpackage : pdc_pkg

// ===== pdc_pull_dec.sv
// Decoder from a two-bit pad pull code to pull-up and pull-down enables
`timescale 1ns/1ns
`default_nettype none
module pdc_pull_dec (
    // Code
    input wire logic [1:0] code,
    // Pad enables
    output pdc_pkg::pdc_pad_type pad
);
    always_comb begin
        pad.pull_up = (code == pdc_pkg::PULL_UP);
        pad.pull_down = (code == pdc_pkg::PULL_DOWN);
    end
endmodule : pdc_pull_dec
`default_nettype wire

// ===== pdc_dejitter.sv
// One dejitter stage: holds a sample until the window has elapsed, then passes it once
`timescale 1ns/1ns
`default_nettype none
module pdc_dejitter (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Window
    input wire logic [7:0] window,
    // Samples
    input wire pdc_pkg::pdc_sample_type din,
    output pdc_pkg::pdc_sample_type dout,
    output logic locked
);
    logic [7:0] cnt_q;
    logic pend_q;
    logic [23:0] hold_q;
    logic bypass;
    assign bypass = (window == 8'h00);
    assign locked = pend_q;
    // Capture each sample, then release it once after the window; a newer sample arriving first replaces the held one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 8'h00;
            pend_q <= 1'b0;
            hold_q <= 24'h000000;
        end else if (bypass) begin
            cnt_q <= 8'h00;
            pend_q <= 1'b0;
            hold_q <= 24'h000000;
        end else if (din.valid) begin
            hold_q <= din.data;
            pend_q <= 1'b1;
            cnt_q <= 8'h00;
        end else if (pend_q) begin
            if (cnt_q + 8'h01 >= window) begin
                pend_q <= 1'b0;
            end
            cnt_q <= cnt_q + 8'h01;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dout <= '0;
        end else if (bypass) begin
            dout <= din;
        end else begin
            dout.valid <= pend_q && !din.valid && (cnt_q + 8'h01 >= window);
            dout.data <= hold_q;
        end
    end
endmodule : pdc_dejitter
`default_nettype wire

// ===== pdc_top.sv
// Pad pull, drive strength, dejitter window and record gain configuration block
// Contract
// [RL1] Latch pad pull code at bits 5:4: 00 up, 01 reserved, 10 none, 11 down.
// [RL2] Control clock pad pull code at bits 3:2, same codes, default none.
// [RL3] Data-in bits 7:6 and data-out bits 1:0 use same codes, default none.
// [RL4] Drive register bit 0 selects data-out drive, zero low, one high.
// [RL5] Jack register bit 5 drive, bits 3:2 pull with usual codes.
// [RL6] Dejitter window is 8 bits in core cycles, shared by all, reset 3.
// [RL7] In slave mode dejitter passes every sample once, none duplicated or skipped; here a newer sample arriving before release replaces the held one.
// [RL8] Disabling then re-enabling a path may stall its dejitter until reset.
// [RL9] Window zero bypasses and resets every dejitter circuit.
// [RL10] Software writes zero then nonzero before output in slave mode.
// [RL11] Writing 3 after zero reactivates dejitter at once, no wait.
// [RL12] Record gain is 6-bit code, 0.75 dB steps, 000000 -12 dB, 010000 0 dB.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module pdc_top #(
    parameter int NCH = 3
) (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RSTN,
    // Register port
    input wire logic [15:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    // Path enables, one per dejitter channel
    input wire logic [NCH-1:0] PATH_EN,
    // Sample streams
    input wire pdc_pkg::pdc_sample_type [NCH-1:0] SAMPLE_IN,
    output pdc_pkg::pdc_sample_type [NCH-1:0] SAMPLE_OUT,
    // Pad controls
    output pdc_pkg::pdc_pad_type LATCH_PAD,
    output pdc_pkg::pdc_pad_type CLOCK_PAD,
    output pdc_pkg::pdc_pad_type DIN_PAD,
    output pdc_pkg::pdc_pad_type DOUT_PAD,
    output pdc_pkg::pdc_pad_type JACK_PAD,
    output logic DOUT_HIGH_DRIVE,
    output logic JACK_HIGH_DRIVE,
    // Record gain in thousandths of a dB
    output logic signed [16:0] REC_GAIN_MDB
);
    logic [7:0] pull_q;
    logic drive_q;
    logic [7:0] jack_q;
    logic [7:0] window_q;
    logic [5:0] rec_vol_q;
    logic [NCH-1:0] locked;
    logic [7:0] rdata_d;

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            pull_q <= pdc_pkg::PULL_CFG_RST;
        end else if (WR && ADDR == pdc_pkg::PULL_CFG_ADDR) begin
            pull_q <= WDATA; // see [RL1] see [RL2] see [RL3]
        end
    end
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            drive_q <= pdc_pkg::DRIVE_RST[0];
        end else if (WR && ADDR == pdc_pkg::DRIVE_ADDR) begin
            drive_q <= WDATA[pdc_pkg::DRV_BIT]; // see [RL4]
        end
    end
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            jack_q <= pdc_pkg::JACK_RST;
        end else if (WR && ADDR == pdc_pkg::JACK_ADDR) begin
            jack_q <= WDATA & 8'h2C; // see [RL5]
        end
    end
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            window_q <= pdc_pkg::DEJITTER_RST; // see [RL6]
        end else if (WR && ADDR == pdc_pkg::DEJITTER_ADDR) begin
            window_q <= WDATA; // see [RL6]
        end
    end
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            rec_vol_q <= pdc_pkg::REC_VOL_RST;
        end else if (WR && ADDR == pdc_pkg::REC_VOL_ADDR) begin
            rec_vol_q <= WDATA[5:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port
    always_comb begin
        unique case (ADDR)
            pdc_pkg::PULL_CFG_ADDR: rdata_d = pull_q;
            pdc_pkg::DRIVE_ADDR: rdata_d = {7'h00, drive_q};
            pdc_pkg::JACK_ADDR: rdata_d = jack_q;
            pdc_pkg::DEJITTER_ADDR: rdata_d = window_q;
            pdc_pkg::REC_VOL_ADDR: rdata_d = {2'h0, rec_vol_q};
            pdc_pkg::DEJITTER_STAT_ADDR: rdata_d = {{(8-NCH){1'b0}}, locked};
            default: rdata_d = 8'h00;
        endcase
    end
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            RDATA <= 8'h00;
        end else if (RD) begin
            RDATA <= rdata_d;
        end else begin
            RDATA <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pads
    pdc_pull_dec u_din (.code(pull_q[pdc_pkg::DIN_LSB +: 2]), .pad(DIN_PAD)); // see [RL3]
    pdc_pull_dec u_latch (.code(pull_q[pdc_pkg::LATCH_LSB +: 2]), .pad(LATCH_PAD)); // see [RL1]
    pdc_pull_dec u_clk (.code(pull_q[pdc_pkg::CLK_LSB +: 2]), .pad(CLOCK_PAD)); // see [RL2]
    pdc_pull_dec u_dout (.code(pull_q[pdc_pkg::DOUT_LSB +: 2]), .pad(DOUT_PAD)); // see [RL3]
    pdc_pull_dec u_jack (.code(jack_q[pdc_pkg::JACK_PULL_LSB +: 2]), .pad(JACK_PAD)); // see [RL5]
    assign DOUT_HIGH_DRIVE = drive_q; // see [RL4]
    assign JACK_HIGH_DRIVE = jack_q[pdc_pkg::JACK_DRV_BIT]; // see [RL5]

    ////////////////////////////////////////////////////////////////////////////
    // Dejitter channels; a disabled path has its input valid masked, window zero bypasses all
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_dj
            pdc_pkg::pdc_sample_type gated;
            always_comb begin
                gated = SAMPLE_IN[g];
                gated.valid = SAMPLE_IN[g].valid && PATH_EN[g]; // see [RL8]
            end
            pdc_dejitter u_dj (
                .clk(MCLK),
                .rst_n(RSTN),
                .window(window_q), // see [RL7] see [RL9] see [RL11]
                .din(gated),
                .dout(SAMPLE_OUT[g]),
                .locked(locked[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Record gain: linear 0.75 dB steps from -12 dB
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            REC_GAIN_MDB <= 17'sh00000;
        end else begin
            // 17 bits so that the top codes, up to +35.25 dB, do not wrap
            REC_GAIN_MDB <= 17'(pdc_pkg::GAIN_BASE_MDB + pdc_pkg::GAIN_STEP_MDB * int'(rec_vol_q)); // see [RL12]
        end
    end
endmodule : pdc_top
`default_nettype wire

// ===== pdc_top_asserts.sv
// Port-level assertions for the pad and dejitter configuration block
`timescale 1ns/1ns
`default_nettype none
module pdc_top_asserts #(
    parameter int NCH = 3
) (
    // Clock, reset and register port
    input wire logic MCLK, RSTN, WR, RD,
    input wire logic [15:0] ADDR,
    input wire logic [7:0] WDATA, RDATA,
    // Samples
    input wire logic [NCH-1:0] PATH_EN,
    input wire pdc_pkg::pdc_sample_type [NCH-1:0] SAMPLE_IN, SAMPLE_OUT,
    // Pads and gain
    input wire pdc_pkg::pdc_pad_type LATCH_PAD, CLOCK_PAD, DIN_PAD, DOUT_PAD, JACK_PAD,
    input wire logic DOUT_HIGH_DRIVE, JACK_HIGH_DRIVE,
    input wire logic signed [16:0] REC_GAIN_MDB
);
    logic [7:0] wd_q;
    logic [7:0] win_q;
    wire logic wp = WR && ADDR == pdc_pkg::PULL_CFG_ADDR;
    wire logic wv = WR && ADDR == pdc_pkg::REC_VOL_ADDR;
    wire logic sv = PATH_EN[0] && SAMPLE_IN[0].valid;
    function automatic logic [1:0] pl(input logic [1:0] c);
        return {c == 2'h0, c == 2'h3};
    endfunction : pl
    always_ff @(posedge MCLK) wd_q <= WDATA;
    // Shadow of the shared window size
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) win_q <= pdc_pkg::DEJITTER_RST;
        else if (WR && ADDR == pdc_pkg::DEJITTER_ADDR) win_q <= WDATA;
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RSTN);
    a_latch_pull: assert property (wp |=> LATCH_PAD == pl(wd_q[5:4])) else $error("latch pull");
    a_clock_pull: assert property (wp |=> CLOCK_PAD == pl(wd_q[3:2])) else $error("clock pull");
    a_data_pull: assert property (wp |=> {DIN_PAD, DOUT_PAD} == {pl(wd_q[7:6]), pl(wd_q[1:0])})
        else $error("data pulls");
    a_dout_drive: assert property (WR && ADDR == pdc_pkg::DRIVE_ADDR |=> DOUT_HIGH_DRIVE == wd_q[0])
        else $error("dout drive");
    a_jack_cfg: assert property (WR && ADDR == pdc_pkg::JACK_ADDR |=>
        JACK_HIGH_DRIVE == wd_q[5] && JACK_PAD == pl(wd_q[3:2])) else $error("jack pin");
    a_window_read: assert property (RD && ADDR == pdc_pkg::DEJITTER_ADDR |=> RDATA == win_q)
        else $error("window read");
    // Captured at the first edge, released at the third edge after it, seen at the fourth
    a_window_delay: assert property (win_q == 8'h03 && sv ##1 !SAMPLE_IN[0].valid [*3] |=>
        SAMPLE_OUT[0].valid && SAMPLE_OUT[0].data == $past(SAMPLE_IN[0].data, 4)) else $error("window delay");
    a_bypass_pass: assert property (win_q == 8'h00 && PATH_EN[0] |=> SAMPLE_OUT[0] == $past(SAMPLE_IN[0]))
        else $error("bypass");
    a_gain_code: assert property (wv |-> ##2 REC_GAIN_MDB ==
        17'(pdc_pkg::GAIN_BASE_MDB + pdc_pkg::GAIN_STEP_MDB * int'($past(wd_q) & 8'h3F))) else $error("gain");
    c_bypass: cover property (win_q == 8'h00 && sv);
    c_window: cover property (win_q == 8'h05 && sv);
    c_gain: cover property (wv && WDATA == 8'h3F);
endmodule : pdc_top_asserts
bind pdc_top pdc_top_asserts #(.NCH(NCH)) u_chk (.*);
`default_nettype wire

// ===== pdc_top_tb.sv
// Self-checking bench for the pad and dejitter configuration block
`timescale 1ns/1ns
`default_nettype none
module pdc_top_tb;
    logic MCLK = 1'b0, RSTN = 1'b0, WR = 1'b0, RD = 1'b0;
    logic [15:0] ADDR = 16'h0000;
    logic [7:0] WDATA = 8'h00, RDATA;
    logic [2:0] PATH_EN = 3'h7;
    pdc_pkg::pdc_sample_type [2:0] SAMPLE_IN = '0, SAMPLE_OUT;
    pdc_pkg::pdc_pad_type LATCH_PAD, CLOCK_PAD, DIN_PAD, DOUT_PAD, JACK_PAD;
    logic DOUT_HIGH_DRIVE, JACK_HIGH_DRIVE;
    logic signed [16:0] REC_GAIN_MDB;
    logic [7:0] wins [5] = '{8'h03, 8'h00, 8'h03, 8'h05, 8'h01};
    int n_errors = 0, total_checks = 0, cyc = 0;
    pdc_top uut (.*);
    always #5 MCLK = ~MCLK;
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [1:0] pl(input logic [1:0] c);
        return {c == 2'h0, c == 2'h3};
    endfunction : pl
    task automatic chk(input logic ok);
        total_checks++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("ERROR %0t mismatch", $time);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge MCLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge MCLK);
        WR <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge MCLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge MCLK);
        RD <= 1'b0;
        #1;
        chk(RDATA === e);
    endtask : rd
    // One sample on every channel, then count cycles to its release
    task automatic send(input logic [7:0] w, input logic [23:0] d);
        int n;
        @(posedge MCLK);
        SAMPLE_IN <= {3{1'b1, d}};
        @(posedge MCLK);
        SAMPLE_IN <= '0;
        #1;
        n = 0;
        while (SAMPLE_OUT[0].valid !== 1'b1 && n < 20) begin
            @(posedge MCLK);
            #1;
            n++;
        end
        chk(n == int'(w));
        chk(SAMPLE_OUT === {3{1'b1, d}});
        @(posedge MCLK);
        #1;
        chk(SAMPLE_OUT[0].valid === 1'b0);
    endtask : send
    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : finish_test
    always @(posedge MCLK) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            finish_test();
        end
    end
    initial begin
        repeat (10) @(posedge MCLK);
        RSTN <= 1'b1;
        rd(pdc_pkg::PULL_CFG_ADDR, 8'hAA);
        rd(pdc_pkg::DRIVE_ADDR, 8'h00);
        rd(pdc_pkg::JACK_ADDR, 8'h08);
        rd(pdc_pkg::DEJITTER_ADDR, 8'h03);
        chk({LATCH_PAD, CLOCK_PAD, DIN_PAD, DOUT_PAD, JACK_PAD} === 10'h000);
        for (int c = 0; c < 4; c++) begin
            wr(pdc_pkg::PULL_CFG_ADDR, {4{2'(c)}});
            chk({LATCH_PAD, CLOCK_PAD, DIN_PAD, DOUT_PAD} === {4{pl(2'(c))}});
            wr(pdc_pkg::JACK_ADDR, {2'b00, c[0], 1'b0, 2'(c), 2'b00});
            chk(JACK_PAD === pl(2'(c)) && JACK_HIGH_DRIVE === c[0]);
            wr(pdc_pkg::DRIVE_ADDR, {7'h00, c[1]});
            chk(DOUT_HIGH_DRIVE === c[1]);
        end
        wr(16'h4050, 8'h55);
        rd(16'h4050, 8'h00);
        $display("pads done");
        for (int k = 0; k < 64; k++) begin
            wr(pdc_pkg::REC_VOL_ADDR, 8'(k));
            @(posedge MCLK);
            #1;
            chk(REC_GAIN_MDB === 17'(pdc_pkg::GAIN_BASE_MDB + pdc_pkg::GAIN_STEP_MDB * k));
        end
        // Top code is +35.25 dB
        chk(REC_GAIN_MDB === 17'sd35250);
        $display("gain done");
        foreach (wins[i]) begin
            wr(pdc_pkg::DEJITTER_ADDR, wins[i]);
            send(wins[i], 24'h0A5100 + 24'(i));
        end
        // Window zero drops a pending sample, then 3 restarts at once
        wr(pdc_pkg::DEJITTER_ADDR, 8'h10);
        @(posedge MCLK);
        SAMPLE_IN <= {3{1'b1, 24'h0C0C0C}};
        @(posedge MCLK);
        SAMPLE_IN <= '0;
        rd(pdc_pkg::DEJITTER_STAT_ADDR, 8'h07);
        wr(pdc_pkg::DEJITTER_ADDR, 8'h00);
        rd(pdc_pkg::DEJITTER_STAT_ADDR, 8'h00);
        chk(SAMPLE_OUT[0].valid === 1'b0);
        wr(pdc_pkg::DEJITTER_ADDR, 8'h03);
        send(8'h03, 24'h0D0D0D);
        // A disabled path passes nothing while the others carry on
        PATH_EN <= 3'h6;
        @(posedge MCLK);
        SAMPLE_IN <= {3{1'b1, 24'h0E0E0E}};
        @(posedge MCLK);
        SAMPLE_IN <= '0;
        repeat (3) @(posedge MCLK);
        #1;
        chk(SAMPLE_OUT[0].valid === 1'b0 && SAMPLE_OUT[1] === {1'b1, 24'h0E0E0E});
        PATH_EN <= 3'h7;
        $display("dejitter done");
        finish_test();
    end
endmodule : pdc_top_tb
`default_nettype wire
